/* File: src/stc_consts.vh */
// constants for the sixteen bit timer/counter: offsets, fields, reset values
// assumes a wishbone slave with byte-wide registers in the low data lane
//
// ============================================================
// Overview of operation
// RL1: count is high and low byte, read/write
// RL2: wrap from all ones raises overflow request
// RL3: capture/compare trigger clears the count
// RL4: control bit 0 gates counting
// RL5: control bit 1 picks external or internal
// RL6: internal source advances per instruction cycle
// RL7: external source advances on rising pin edge
// RL8: timer, sync counter, async counter modes
// RL9: control bit 2 bypasses external sync
// RL10: bits 5-4 divide input by 1,2,4,8
// RL11: control bit 3 enables low power oscillator
// RL12: control bits 7-6 read zero, ignore writes
// RL13: control at 10h, resets to zero
// RL14: overflow flag sticky, low carries into high
`ifndef STC_CONSTS_VH
`define STC_CONSTS_VH

// ============================================================
// register byte addresses
`define STC_ADDR_CONTROL    8'h10
`define STC_ADDR_COUNT_LOW  8'h14
`define STC_ADDR_COUNT_HIGH 8'h18
`define STC_ADDR_IRQ_STATUS 8'h1c
`define STC_ADDR_IRQ_MASK   8'h20

// ============================================================
// control fields
`define STC_BIT_ENABLE      0
`define STC_BIT_SOURCE      1
`define STC_BIT_SYNC_BYPASS 2
`define STC_BIT_OSC_ENABLE  3
`define STC_DIV_LSB         4
`define STC_DIV_MSB         5
`define STC_CONTROL_MASK    8'h3f
`define STC_CONTROL_RESET   8'h00
`define STC_COUNT_RESET     8'h00
`define STC_IRQ_RESET       1'b0

// ============================================================
// timing
`define STC_INSTR_DIV       2'h3

`endif

/* File: src/stc_sync2.v */
// two flip-flop synchroniser for one level
// assumes the input may change at any time relative to clk_in
`timescale 1ns/1ps
`default_nettype none
module stc_sync2 (
	// clock and reset
	input  wire clk_in,
	input  wire reset_n_in,
	// level
	input  wire level_in,
	output wire level_out
);
	reg meta_r;
	reg sync_r;

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= level_in;
			sync_r <= meta_r;
		end
	end

	assign level_out = sync_r;
endmodule // stc_sync2
`default_nettype wire

/* File: src/stc_prescaler.v */
// input divider: passes one of every 1, 2, 4 or 8 tick pulses
// assumes tick_in is a one-cycle pulse; clear_in restarts the count
`timescale 1ns/1ps
`default_nettype none
module stc_prescaler (
	// clock and reset
	input  wire       clk_in,
	input  wire       reset_n_in,
	// control
	input  wire [1:0] divide_in,
	input  wire       clear_in,
	// ticks
	input  wire       tick_in,
	output wire       tick_out
);
	reg  [2:0] count_r;
	wire [2:0] limit;

	// ============================================================
	// division
	assign limit = (3'h1 << divide_in) - 3'h1; // RL10
	assign tick_out = tick_in && (count_r >= limit); // RL10

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_r <= 3'h0;
		end else if (clear_in) begin
			count_r <= 3'h0;
		end else if (tick_in) begin
			if (count_r >= limit) begin
				count_r <= 3'h0;
			end else begin
				count_r <= count_r + 3'h1;
			end
		end
	end
endmodule // stc_prescaler
`default_nettype wire

/* File: src/stc_timer.v */
// sixteen bit timer/counter with a classic wishbone register slave
// assumes clk_in is the oscillator clock and the external pin is slow
// against it; the trigger input is a one-cycle pulse in this domain
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.vh"
module stc_timer (
	// clock and reset
	input  wire       clk_in,
	input  wire       reset_n_in,
	// wishbone slave
	input  wire       wb_cyc_in,
	input  wire       wb_stb_in,
	input  wire       wb_we_in,
	input  wire [7:0] wb_adr_in,
	input  wire [3:0] wb_sel_in,
	input  wire [31:0] wb_dat_in,
	output reg  [31:0] wb_dat_out,
	output reg        wb_ack_out,
	output wire       wb_err_out,
	// counter pins and triggers
	input  wire       ext_count_pin_in,
	input  wire       special_trigger_in,
	output wire       osc_enable_out,
	// interrupt
	output wire       irq_out
);
	// ============================================================
	// registers
	reg  [7:0] control_r;
	reg  [7:0] count_low_r;
	reg  [7:0] count_high_r;
	reg        ovf_flag_r;
	reg        ovf_mask_r;
	reg  [1:0] instr_div_r;
	reg        pin_prev_r;
	reg        raw_prev_r;
	reg  [7:0] rd_nxt;
	reg        hit;

	wire       enable;
	wire       src_ext;
	wire       bypass;
	wire       pin_sync;
	wire       ext_level;
	wire       ext_edge;
	wire       instr_tick;
	wire       src_tick;
	wire       cnt_tick;
	wire       wrap;
	wire       bus_req;
	wire       bus_wr;
	wire       bus_rd;
	wire       lane0;

	assign enable  = control_r[`STC_BIT_ENABLE];
	assign src_ext = control_r[`STC_BIT_SOURCE];
	assign bypass  = control_r[`STC_BIT_SYNC_BYPASS];
	assign osc_enable_out = control_r[`STC_BIT_OSC_ENABLE]; // RL11

	// ============================================================
	// count source
	stc_sync2 u_pin_sync (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.level_in   (ext_count_pin_in),
		.level_out  (pin_sync)
	);

	// async mode takes the pin through one flop, not two, saving one cycle of latency; the
	// edge detector still samples it, so the pin must be slow and clean
	assign ext_level = bypass ? raw_prev_r : pin_sync; // RL9
	assign ext_edge  = ext_level && !pin_prev_r; // RL7

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			raw_prev_r  <= 1'b0;
			pin_prev_r  <= 1'b0;
			instr_div_r <= 2'h0;
		end else begin
			raw_prev_r  <= ext_count_pin_in;
			pin_prev_r  <= ext_level;
			instr_div_r <= instr_div_r + 2'h1;
		end
	end

	assign instr_tick = (instr_div_r == `STC_INSTR_DIV); // RL6
	assign src_tick   = src_ext ? ext_edge : instr_tick; // RL5 RL8

	stc_prescaler u_prescaler (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.divide_in  (control_r[`STC_DIV_MSB:`STC_DIV_LSB]),
		.clear_in   (bus_wr && (wb_adr_in == `STC_ADDR_COUNT_LOW ||
		             wb_adr_in == `STC_ADDR_COUNT_HIGH)),
		.tick_in    (src_tick && enable),
		.tick_out   (cnt_tick)
	);

	assign wrap = cnt_tick && (count_high_r == 8'hff) && (count_low_r == 8'hff); // RL2

	// ============================================================
	// wishbone decode
	assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign bus_wr  = bus_req && wb_we_in && lane0;
	assign bus_rd  = bus_req && !wb_we_in;
	assign lane0   = wb_sel_in[0];
	assign wb_err_out = 1'b0;

	always @* begin
		hit   = 1'b1;
		rd_nxt = 8'h00;
		case (wb_adr_in)
			`STC_ADDR_CONTROL:    rd_nxt = control_r & `STC_CONTROL_MASK; // RL12
			`STC_ADDR_COUNT_LOW:  rd_nxt = count_low_r; // RL1
			`STC_ADDR_COUNT_HIGH: rd_nxt = count_high_r; // RL1
			`STC_ADDR_IRQ_STATUS: rd_nxt = {7'h00, ovf_flag_r};
			`STC_ADDR_IRQ_MASK:   rd_nxt = {7'h00, ovf_mask_r};
			default:              hit = 1'b0;
		endcase
	end

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= bus_req;
			if (bus_rd) begin
				wb_dat_out <= {24'h000000, hit ? rd_nxt : 8'h00};
			end
		end
	end

	// ============================================================
	// control and interrupt registers
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			control_r  <= `STC_CONTROL_RESET; // RL13
			ovf_mask_r <= `STC_IRQ_RESET;
			ovf_flag_r <= `STC_IRQ_RESET;
		end else begin
			if (bus_wr && wb_adr_in == `STC_ADDR_CONTROL) begin
				control_r <= wb_dat_in[7:0] & `STC_CONTROL_MASK; // RL12
			end
			if (bus_wr && wb_adr_in == `STC_ADDR_IRQ_MASK) begin
				ovf_mask_r <= wb_dat_in[0];
			end
			// set beats the clear-on-read in the same cycle
			if (wrap) begin
				ovf_flag_r <= 1'b1; // RL14
			end else if (bus_rd && wb_adr_in == `STC_ADDR_IRQ_STATUS) begin
				ovf_flag_r <= 1'b0;
			end
		end
	end

	assign irq_out = ovf_flag_r && ovf_mask_r; // RL2

	// ============================================================
	// counter
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_low_r  <= `STC_COUNT_RESET;
			count_high_r <= `STC_COUNT_RESET;
		end else if (special_trigger_in) begin
			count_low_r  <= `STC_COUNT_RESET; // RL3
			count_high_r <= `STC_COUNT_RESET; // RL3
		end else if (bus_wr && wb_adr_in == `STC_ADDR_COUNT_LOW) begin
			count_low_r <= wb_dat_in[7:0]; // RL1
		end else if (bus_wr && wb_adr_in == `STC_ADDR_COUNT_HIGH) begin
			count_high_r <= wb_dat_in[7:0]; // RL1
		end else if (cnt_tick) begin // RL4
			count_low_r <= count_low_r + 8'h01;
			if (count_low_r == 8'hff) begin
				count_high_r <= count_high_r + 8'h01; // RL14
			end
		end
	end
endmodule // stc_timer
`default_nettype wire

/* File: verification/stc_timer_asserts.sv */
// checker for the timer/counter register slave and interrupt output
// assumes it is bound onto stc_timer; one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.vh"
module stc_timer_asserts (
	input wire logic        clk_in, reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in,
	input wire logic [7:0]  wb_adr_in,
	input wire logic [3:0]  wb_sel_in,
	input wire logic [31:0] wb_dat_in, wb_dat_out,
	input wire logic        wb_ack_out, wb_err_out, ext_count_pin_in, special_trigger_in,
	input wire logic        osc_enable_out, irq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// ==========
	// taken request, taken write
	wire tk = wb_cyc_in & wb_stb_in & !wb_ack_out;
	wire wr = tk & wb_we_in & wb_sel_in[0];
	AST_ACK_NEXT: assert property (tk |=> wb_ack_out)
		else $error("ack missing one cycle after request");
	AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	AST_NO_ERR: assert property (!wb_err_out)
		else $error("error response raised");
	AST_HI_ZERO: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
		else $error("upper read data not zero");
	AST_CTL_TOP: assert property (tk && !wb_we_in && wb_adr_in == `STC_ADDR_CONTROL
		|=> wb_dat_out[7:6] == 2'h0)
		else $error("unused control bits read nonzero");
	AST_OSC: assert property (wr && wb_adr_in == `STC_ADDR_CONTROL
		|-> ##2 osc_enable_out == $past(wb_dat_in[3], 2))
		else $error("oscillator enable not following control");
	AST_TRIG: assert property ($past(special_trigger_in) && special_trigger_in && tk
		&& !wb_we_in && wb_adr_in == `STC_ADDR_COUNT_LOW |=> wb_dat_out[7:0] == 8'h0)
		else $error("count not held at zero by trigger");
	AST_MASK_OFF: assert property (wr && wb_adr_in == `STC_ADDR_IRQ_MASK && !wb_dat_in[0]
		|=> !irq_out [*2])
		else $error("interrupt high while masked");
	cover property (wr && wb_adr_in == `STC_ADDR_CONTROL);
	cover property ($rose(irq_out));
	cover property ($rose(ext_count_pin_in));
endmodule // stc_timer_asserts
bind stc_timer stc_timer_asserts u_chk (.*);
`default_nettype wire

/* File: verification/stc_pin_src.sv */
// external count source driving the counter pin
// assumes the bench clock; half_in of zero parks the pin low
`timescale 1ns/1ps
`default_nettype none
module stc_pin_src (
	input  wire logic       clk_in,
	input  wire logic [3:0] half_in,
	output var  logic       pin_out
);
	int cnt = 0;
	initial pin_out = 1'b0;
	// pin toggles every half_in clocks without pause, a free-running square wave
	always @(posedge clk_in) begin
		cnt <= (half_in == 4'h0 || cnt + 1 >= half_in) ? 0 : cnt + 1;
		if (half_in == 4'h0) pin_out <= 1'b0;
		else if (cnt + 1 >= half_in) pin_out <= !pin_out;
	end
endmodule // stc_pin_src
`default_nettype wire

/* File: verification/tb_sixteen_bit_timer_counter.sv */
// self-checking bench for the sixteen bit timer/counter
// assumes stc_timer, its bound checker and the pin source model
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.vh"
module tb_sixteen_bit_timer_counter;
	logic        clk_in = 1'b0, reset_n_in = 1'b0, cyc = 1'b0, we = 1'b0, trig = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat, lf = 32'hf2e5dcdb;
	logic [3:0]  half = 4'h0;
	wire logic [31:0] dout;
	wire logic   ack, osc, irq, pin;
	int          bad_count = 0, n_compared = 0, cyc_n = 0, edges = 0, t0, k;
	always #50 clk_in = !clk_in;
	always @(posedge clk_in) cyc_n <= cyc_n + 1;
	always @(posedge pin) edges <= edges + 1;
	stc_pin_src src_u (.clk_in(clk_in), .half_in(half), .pin_out(pin));
	stc_timer dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
		.wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1),
		.wb_dat_in(dat), .wb_dat_out(dout), .wb_ack_out(ack), .wb_err_out(),
		.ext_count_pin_in(pin), .special_trigger_in(trig), .osc_enable_out(osc),
		.irq_out(irq));
	// ==========
	// helpers
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// master waits for ack with no assumed latency; timeout guards a dead slave
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
		do begin @(posedge clk_in); n++; end while (ack !== 1'b1 && n < 50);
		if (n >= 50) bad_count++;
		rdat = dout;
		cyc <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin bad_count++; $display("Error %0t exp %h got %h", $time, e, g); end
	endtask
	// tick phase is free running, so one count of slack either way
	task automatic chk_near(input int e, input logic [7:0] g);
		n_compared++;
		if ($isunknown(g) || int'(g) > e + 1 || int'(g) + 1 < e) begin
			bad_count++; $display("Error %0t exp %h got %h", $time, e, g); end
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin #2000000; bad_count++; wrap_up; end
	// ==========
	// scenarios
	initial begin
		repeat (8) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge clk_in);
		for (k = 0; k < 6; k++) begin bus(0, 8'h10 + 8'(4 * k), 8'h0); chk(0, rdat); end
		for (k = 0; k < 4; k++) begin
			lf = nx(lf);
			bus(1, `STC_ADDR_CONTROL, lf[7:0] & 8'hfe);
			bus(0, `STC_ADDR_CONTROL, 8'h0);
			chk({24'h0, lf[7:0] & 8'h3e}, rdat);
			chk({31'h0, lf[3]}, {31'h0, osc});
		end
		bus(1, `STC_ADDR_CONTROL, 8'h00);
		lf = nx(lf);
		bus(1, `STC_ADDR_COUNT_LOW, lf[7:0]);
		bus(1, `STC_ADDR_COUNT_HIGH, lf[15:8]);
		repeat (40) @(posedge clk_in);
		bus(0, `STC_ADDR_COUNT_LOW, 8'h0); chk({24'h0, lf[7:0]}, rdat);
		bus(0, `STC_ADDR_COUNT_HIGH, 8'h0); chk({24'h0, lf[15:8]}, rdat);
		// mode first, then the count write restarts count and divider together
		for (k = 0; k < 4; k++) begin
			bus(1, `STC_ADDR_CONTROL, {2'h0, k[1:0], 4'h1});
			bus(1, `STC_ADDR_COUNT_LOW, 8'h0); t0 = cyc_n;
			repeat (32 << k) @(posedge clk_in);
			bus(0, `STC_ADDR_COUNT_LOW, 8'h0);
			chk_near((cyc_n - t0) / (4 << k), rdat[7:0]);
		end
		half <= 4'h3;
		for (k = 0; k < 2; k++) begin
			bus(1, `STC_ADDR_CONTROL, {5'h0, k[0], 2'h3});
			bus(1, `STC_ADDR_COUNT_LOW, 8'h0); t0 = edges;
			repeat (60) @(posedge clk_in);
			bus(0, `STC_ADDR_COUNT_LOW, 8'h0);
			chk_near(edges - t0, rdat[7:0]);
		end
		half <= 4'h0;
		bus(1, `STC_ADDR_IRQ_MASK, 8'h01);
		bus(1, `STC_ADDR_COUNT_LOW, 8'hff);
		bus(1, `STC_ADDR_COUNT_HIGH, 8'hff);
		bus(1, `STC_ADDR_CONTROL, 8'h01);
		repeat (12) @(posedge clk_in);
		chk(1, {31'h0, irq});
		bus(0, `STC_ADDR_COUNT_HIGH, 8'h0); chk(0, rdat);
		bus(1, `STC_ADDR_IRQ_MASK, 8'h00); chk(0, {31'h0, irq});
		bus(0, `STC_ADDR_IRQ_STATUS, 8'h0); chk(1, rdat);
		bus(0, `STC_ADDR_IRQ_STATUS, 8'h0); chk(0, rdat);
		trig <= 1'b1;
		repeat (2) @(posedge clk_in);
		bus(0, `STC_ADDR_COUNT_LOW, 8'h0); chk(0, rdat);
		trig <= 1'b0;
		wrap_up;
	end
endmodule // tb_sixteen_bit_timer_counter
`default_nettype wire
